// File: pkg/hpc_pkg.sv
/*
  Shared constants and types for the second host port channel: status
  and control bit positions, reset values, slave register selects and
  the carrier structs for host pins and captured host words.
  Assumes a single core clock and that every user imports nothing.
*/
package hpc_pkg;

  // Synchroniser depth for every pin that comes from the host
  localparam int unsigned SYNC_STAGES = 3;

  // Depth of the buffer between host capture and the input register
  localparam int unsigned BUF_DEPTH = 2;

  localparam int unsigned BYTE_W = 8;

  // Handshake status bit positions
  localparam int unsigned ST_OUT_FULL_BIT = 0;
  localparam int unsigned ST_IN_FULL_BIT  = 1;
  localparam int unsigned ST_CMD_BIT      = 3;

  // Bits the slave may write in the status register
  localparam logic [7:0] ST_USER_MASK = 8'hf4;
  localparam logic [7:0] ST_RESET     = 8'h00;

  // Serial/timer control register
  localparam int unsigned CTRL_PIN_SWITCH_BIT = 3;
  localparam logic [7:0]  CTRL_RESET          = 8'h00;

  // Slave-side register selects; no offsets exist, the select is a code
  typedef enum logic [1:0] {
    HPC_SEL_INPUT   = 2'h0,
    HPC_SEL_OUTPUT  = 2'h1,
    HPC_SEL_STATUS  = 2'h2,
    HPC_SEL_CONTROL = 2'h3
  } hpc_reg_sel_t;

  // Host pins as one bundle for the synchroniser
  typedef struct packed {
    logic [7:0] data;
    logic       addr;
    logic       sel_two_n;
    logic       alt_sel_two_n;
    logic       store_n;
    logic       alt_store_n;
    logic       fetch_n;
    logic       sel_one_n;
  } hpc_pins_t;

  // Idle level of the pins: strobes and selects high
  localparam hpc_pins_t PINS_IDLE = '{
    data:          8'h00,
    addr:          1'b0,
    sel_two_n:     1'b1,
    alt_sel_two_n: 1'b1,
    store_n:       1'b1,
    alt_store_n:   1'b1,
    fetch_n:       1'b1,
    sel_one_n:     1'b1
  };

  // Word captured from one host write
  typedef struct packed {
    logic       cmd;
    logic [7:0] data;
  } hpc_word_t;

endpackage : hpc_pkg

// File: logic/hpc_sync.sv
/*
  Multi-bit pin synchroniser with a filter that waits for stages two and three to agree.
  Assumes each bit is independent; multi-bit words must be qualified
  by a strobe that passes the same pipeline.
*/
module hpc_sync #(
  parameter int unsigned    WIDTH     = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] stable_out
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  logic [WIDTH-1:0] next_stable;

  // A bit counts only once the second and third stages agree
  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      next_stable[i] = (stage2[i] == stage3[i]) ? stage3[i] : stable_out[i];
    end
  end

  // Stage one feeds stage two only, to keep metastability contained
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      stage1     <= RESET_VAL;
      stage2     <= RESET_VAL;
      stage3     <= RESET_VAL;
      stable_out <= RESET_VAL;
    end else begin
      stage1     <= async_in;
      stage2     <= stage1;
      stage3     <= stage2;
      stable_out <= next_stable;
    end
  end

endmodule : hpc_sync

// File: logic/hpc_buffer.sv
/*
  Small FIFO with valid/ready on both sides and honest full/empty.
  Assumes the consumer may hold out_ready low for any time.
*/
module hpc_buffer #(
  parameter int unsigned WIDTH = 9,
  parameter int unsigned DEPTH = 2
) (
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int unsigned PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int unsigned CNT_W = $clog2(DEPTH + 1);
  localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);
  localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wr_ptr;
  logic [PTR_W-1:0] rd_ptr;
  logic [CNT_W-1:0] count;
  logic [PTR_W-1:0] next_wr_ptr;
  logic [PTR_W-1:0] next_rd_ptr;
  logic [CNT_W-1:0] next_count;
  logic             push;
  logic             pop;

  assign in_ready  = (count != CNT_FULL);
  assign out_valid = (count != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rd_ptr];

  // Pointer and occupancy update
  always_comb begin
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count  = count;
    if (push) begin
      next_wr_ptr = (wr_ptr == PTR_LAST) ? '0 : wr_ptr + PTR_W'(1);
    end
    if (pop) begin
      next_rd_ptr = (rd_ptr == PTR_LAST) ? '0 : rd_ptr + PTR_W'(1);
    end
    if (push && !pop) begin
      next_count = count + CNT_W'(1);
    end else if (pop && !push) begin
      next_count = count - CNT_W'(1);
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
    end
  end

  // Storage needs no reset; empty flag hides stale words
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

endmodule : hpc_buffer

// File: logic/hpc_channel_two.sv
/*
  Second channel of the parallel host port: input and output byte
  registers, handshake status, the serial/timer control register and
  the pin switch for select and store strobe.
  Assumes host pins are asynchronous to core_clk, and that the slave
  CPU strobes slv_rd_n / slv_wr_n are synchronous to core_clk.
*/
// Contract
// - Host write rising edge with select low captures data byte into input register.
// - Each host write also stores the address line into the command flag.
// - Input register is eight bits, slave read only, host write only.
// - Input and output bytes have no reset value.
// - Output byte is driven only with address, select and fetch strobe low.
// - Output register is eight bits, slave read/write, host read only.
// - Status register clears to zero on reset and standby.
// - Status bits 7..4 and 2 are user flags, slave writable, host readable.
// - Status bits 3, 1, 0 ignore all writes; only hardware changes them.
// - Command flag is 1 with address high, 0 with address low.
// - Input-full flag sets on host write to the input register.
// - Input-full flag clears at falling edge of slave read of input register.
// - Input-full flag is an interrupt source to the slave.
// - Output-full flag sets at falling edge of slave write of output register.
// - Output-full flag clears at rising edge of host read of output register.
// - Control bit 3 picks primary or alternate select and store pins.
// - Pin switch acts only while the host port is enabled.
// - Serial/timer control register clears to zero on reset and standby.
// - Input-full interrupt forwarded only while its enable bit is 1.
// - Host transfers take effect only while the host port is enabled.
// - Address high with select low, other select high, fetch low returns status.
module hpc_channel_two (
  input  wire logic                core_clk,
  input  wire logic                rst_n,
  input  wire logic                standby,
  input  wire logic                host_port_enable,
  input  wire logic                input_full_irq_enable_two,
  input  wire logic [7:0]          host_data_in,
  output logic      [7:0]          host_data_out,
  output logic                     host_data_oe,
  input  wire logic                host_addr_bit0,
  input  wire logic                host_select_two_n,
  input  wire logic                alt_host_select_two_n,
  input  wire logic                host_store_strobe_n,
  input  wire logic                alt_host_store_strobe_n,
  input  wire logic                host_fetch_strobe_n,
  input  wire logic                host_select_one_n,
  output logic                     host_write_ready,
  input  wire hpc_pkg::hpc_reg_sel_t slv_reg_sel,
  input  wire logic                slv_rd_n,
  input  wire logic                slv_wr_n,
  input  wire logic [7:0]          slv_wdata,
  output logic      [7:0]          slv_rdata,
  output logic                     irq_input_full_two,
  output logic                     select_pin_switch
);

  hpc_pkg::hpc_pins_t pins_raw;
  hpc_pkg::hpc_pins_t pins_now;
  hpc_pkg::hpc_pins_t pins_prev;
  hpc_pkg::hpc_pins_t next_pins_prev;
  hpc_pkg::hpc_word_t cap_word;
  hpc_pkg::hpc_word_t buf_word;

  logic [7:0] host_input_byte_two;
  logic [7:0] host_output_byte_two;
  logic [7:0] user_flag_bits;
  logic [7:0] serial_timer_control;
  logic [7:0] host_handshake_status_two;
  logic       input_full_flag;
  logic       output_full_flag;
  logic       cmd_flag;
  logic       slv_rd_prev;
  logic       slv_wr_prev;

  logic [7:0] next_input_byte;
  logic [7:0] next_output_byte;
  logic [7:0] next_user_bits;
  logic [7:0] next_control;
  logic       next_input_full;
  logic       next_output_full;
  logic       next_cmd_flag;
  logic [7:0] next_host_data_out;
  logic [7:0] next_slv_rdata;

  logic use_alt;
  logic sel_now_n;
  logic sel_prev_n;
  logic store_now_n;
  logic store_prev_n;
  logic sel_raw_n;
  logic host_write_evt;
  logic host_read_out_evt;
  logic slv_rd_fall;
  logic slv_wr_fall;
  logic slv_reading_input;
  logic buf_valid;
  logic buf_ready;
  logic buf_pop;
  logic clear_all;

  // Standby behaves like reset for the handshake flags, user bits, control register and input buffer
  assign clear_all = !rst_n || standby;

  // Bundle the asynchronous pins for one synchroniser instance
  assign pins_raw = '{
    data:          host_data_in,
    addr:          host_addr_bit0,
    sel_two_n:     host_select_two_n,
    alt_sel_two_n: alt_host_select_two_n,
    store_n:       host_store_strobe_n,
    alt_store_n:   alt_host_store_strobe_n,
    fetch_n:       host_fetch_strobe_n,
    sel_one_n:     host_select_one_n
  };

  // Data passes the same pipeline as the strobes, so they stay aligned
  hpc_sync #(
    .WIDTH     ($bits(hpc_pkg::hpc_pins_t)),
    .RESET_VAL (hpc_pkg::PINS_IDLE)
  ) u_pin_sync (
    .core_clk   (core_clk),
    .rst_n      (rst_n),
    .async_in   (pins_raw),
    .stable_out (pins_now)
  );

  // Switch is honoured only in slave mode
  assign use_alt      = host_port_enable && serial_timer_control[hpc_pkg::CTRL_PIN_SWITCH_BIT];
  assign sel_now_n    = use_alt ? pins_now.alt_sel_two_n : pins_now.sel_two_n;
  assign sel_prev_n   = use_alt ? pins_prev.alt_sel_two_n : pins_prev.sel_two_n;
  assign store_now_n  = use_alt ? pins_now.alt_store_n : pins_now.store_n;
  assign store_prev_n = use_alt ? pins_prev.alt_store_n : pins_prev.store_n;
  assign sel_raw_n    = use_alt ? alt_host_select_two_n : host_select_two_n;

  // Host write ends on the rising store edge; data is the last low sample
  assign host_write_evt = host_port_enable && !store_prev_n && store_now_n
                          && !sel_prev_n;
  assign cap_word.data  = pins_prev.data;
  assign cap_word.cmd   = pins_prev.addr;

  // Host read of the output byte completes on the rising fetch edge
  assign host_read_out_evt = host_port_enable && !pins_prev.fetch_n && pins_now.fetch_n
                             && !sel_prev_n && pins_prev.sel_one_n
                             && !pins_prev.addr;

  // Slave strobes share the core clock, so plain edge detection suffices
  assign slv_rd_fall       = slv_rd_prev && !slv_rd_n;
  assign slv_wr_fall       = slv_wr_prev && !slv_wr_n;
  assign slv_reading_input = !slv_rd_n && (slv_reg_sel == hpc_pkg::HPC_SEL_INPUT);

  // Input register is held steady while the slave reads it
  assign buf_ready = !slv_reading_input;
  assign buf_pop   = buf_valid && buf_ready;

  // Two-entry buffer absorbs host writes while the slave read stalls
  hpc_buffer #(
    .WIDTH ($bits(hpc_pkg::hpc_word_t)),
    .DEPTH (hpc_pkg::BUF_DEPTH)
  ) u_in_buffer (
    .core_clk  (core_clk),
    .rst_n     (!clear_all),
    .in_valid  (host_write_evt),
    .in_ready  (host_write_ready),
    .in_data   (cap_word),
    .out_valid (buf_valid),
    .out_ready (buf_ready),
    .out_data  (buf_word)
  );

  // Status image as both sides see it
  always_comb begin
    host_handshake_status_two = user_flag_bits & hpc_pkg::ST_USER_MASK;
    host_handshake_status_two[hpc_pkg::ST_CMD_BIT]      = cmd_flag;
    host_handshake_status_two[hpc_pkg::ST_IN_FULL_BIT]  = input_full_flag;
    host_handshake_status_two[hpc_pkg::ST_OUT_FULL_BIT] = output_full_flag;
  end

  // Next values for the data bytes; no reset on these
  always_comb begin
    next_input_byte  = host_input_byte_two;
    next_output_byte = host_output_byte_two;
    if (buf_pop) begin
      next_input_byte = buf_word.data;
    end
    if (slv_wr_fall && slv_reg_sel == hpc_pkg::HPC_SEL_OUTPUT) begin
      next_output_byte = slv_wdata;
    end
  end

  // Data bytes keep whatever was there until first written
  always_ff @(posedge core_clk) begin
    host_input_byte_two  <= next_input_byte;
    host_output_byte_two <= next_output_byte;
  end

  // Handshake flags; a set in the same cycle as a clear wins
  always_comb begin
    next_cmd_flag    = cmd_flag;
    next_input_full  = input_full_flag;
    next_output_full = output_full_flag;
    next_user_bits   = user_flag_bits;
    next_control     = serial_timer_control;
    if (slv_rd_fall && slv_reg_sel == hpc_pkg::HPC_SEL_INPUT) begin
      next_input_full = 1'b0;
    end
    if (buf_pop) begin
      next_input_full = 1'b1;
      next_cmd_flag   = buf_word.cmd;
    end
    if (host_read_out_evt) begin
      next_output_full = 1'b0;
    end
    if (slv_wr_fall) begin
      unique case (slv_reg_sel)
        hpc_pkg::HPC_SEL_OUTPUT: begin
          next_output_full = 1'b1;
        end
        hpc_pkg::HPC_SEL_STATUS: begin
          // Hardware-owned bits are masked out of the write
          next_user_bits = slv_wdata & hpc_pkg::ST_USER_MASK;
        end
        hpc_pkg::HPC_SEL_CONTROL: begin
          next_control = slv_wdata;
        end
        hpc_pkg::HPC_SEL_INPUT: begin
          next_control = serial_timer_control;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (clear_all) begin
      cmd_flag             <= hpc_pkg::ST_RESET[hpc_pkg::ST_CMD_BIT];
      input_full_flag      <= hpc_pkg::ST_RESET[hpc_pkg::ST_IN_FULL_BIT];
      output_full_flag     <= hpc_pkg::ST_RESET[hpc_pkg::ST_OUT_FULL_BIT];
      user_flag_bits       <= hpc_pkg::ST_RESET;
      serial_timer_control <= hpc_pkg::CTRL_RESET;
    end else begin
      cmd_flag             <= next_cmd_flag;
      input_full_flag      <= next_input_full;
      output_full_flag     <= next_output_full;
      user_flag_bits       <= next_user_bits;
      serial_timer_control <= next_control;
    end
  end

  // Read-back and host drive data
  always_comb begin
    next_slv_rdata     = slv_rdata;
    next_pins_prev     = pins_now;
    next_host_data_out = pins_now.addr ? host_handshake_status_two
                                       : host_output_byte_two;
    if (!slv_rd_n) begin
      unique case (slv_reg_sel)
        hpc_pkg::HPC_SEL_INPUT:   next_slv_rdata = host_input_byte_two;
        hpc_pkg::HPC_SEL_OUTPUT:  next_slv_rdata = host_output_byte_two;
        hpc_pkg::HPC_SEL_STATUS:  next_slv_rdata = host_handshake_status_two;
        hpc_pkg::HPC_SEL_CONTROL: next_slv_rdata = serial_timer_control;
      endcase
    end
  end

  // Edge history and registered data outputs
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pins_prev     <= hpc_pkg::PINS_IDLE;
      slv_rd_prev   <= 1'b1;
      slv_wr_prev   <= 1'b1;
      slv_rdata     <= 8'h00;
      host_data_out <= 8'h00;
    end else begin
      pins_prev     <= next_pins_prev;
      slv_rd_prev   <= slv_rd_n;
      slv_wr_prev   <= slv_wr_n;
      slv_rdata     <= next_slv_rdata;
      host_data_out <= next_host_data_out;
    end
  end

  // Enable follows raw pins so the bus is released without delay;
  // the data behind it lags the address pin by the sync latency plus one register cycle
  assign host_data_oe = host_port_enable && !sel_raw_n && !host_fetch_strobe_n
                        && host_select_one_n;

  assign irq_input_full_two = input_full_flag && input_full_irq_enable_two;
  assign select_pin_switch  = serial_timer_control[hpc_pkg::CTRL_PIN_SWITCH_BIT];

endmodule : hpc_channel_two

// File: test/hpc_channel_two_chk.sv
/* Port checker for the second host port channel.
   Assumes it is bound to hpc_channel_two, one clock, sync reset. */
module hpc_channel_two_chk (
  input wire logic                  core_clk,
  input wire logic                  rst_n,
  input wire logic                  standby,
  input wire logic                  host_port_enable,
  input wire logic                  input_full_irq_enable_two,
  input wire logic                  host_data_oe,
  input wire logic                  host_select_two_n,
  input wire logic                  alt_host_select_two_n,
  input wire logic                  host_fetch_strobe_n,
  input wire logic                  host_select_one_n,
  input wire logic                  host_write_ready,
  input wire hpc_pkg::hpc_reg_sel_t slv_reg_sel,
  input wire logic                  slv_rd_n,
  input wire logic                  slv_wr_n,
  input wire logic [7:0]            slv_wdata,
  input wire logic [7:0]            slv_rdata,
  input wire logic                  irq_input_full_two,
  input wire logic                  select_pin_switch
);
  timeunit 1ns;
  timeprecision 1ns;
  logic sel_eff_n;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  // Alternate select counts only in slave mode
  assign sel_eff_n = (host_port_enable && select_pin_switch) ? alt_host_select_two_n
                                                             : host_select_two_n;

  // Slave accesses are taken on the falling edge of the strobe
  sequence wr_ctrl_s;
    $fell(slv_wr_n) && slv_reg_sel == hpc_pkg::HPC_SEL_CONTROL;
  endsequence
  sequence rd_in_s;
    $fell(slv_rd_n) && slv_reg_sel == hpc_pkg::HPC_SEL_INPUT && input_full_irq_enable_two;
  endsequence

  a_oe_decode: assert property (
    host_data_oe == (host_port_enable && !sel_eff_n && !host_fetch_strobe_n && host_select_one_n))
    else $error("host drive enable disagrees with pins");
  a_oe_disabled: assert property (
    !host_port_enable |-> !host_data_oe)
    else $error("host bus driven while port disabled");
  a_irq_gated: assert property (
    !input_full_irq_enable_two |-> !irq_input_full_two)
    else $error("input-full interrupt while disabled");
  a_standby_clears: assert property (
    standby |=> !select_pin_switch && !irq_input_full_two && host_write_ready)
    else $error("standby left state behind");
  a_ctrl_write: assert property (
    wr_ctrl_s ##0 !standby |=> select_pin_switch == $past(slv_wdata[3]))
    else $error("pin switch did not take written bit");
  a_ctrl_hold: assert property (
    !standby && !($fell(slv_wr_n) && slv_reg_sel == hpc_pkg::HPC_SEL_CONTROL)
      |=> $stable(select_pin_switch))
    else $error("pin switch changed without a write");
  a_irq_status: assert property (
    !slv_rd_n && slv_reg_sel == hpc_pkg::HPC_SEL_STATUS && input_full_irq_enable_two
      |=> slv_rdata[1] == $past(irq_input_full_two))
    else $error("status input-full bit differs from interrupt");
  a_rd_clears: assert property (
    rd_in_s |=> !irq_input_full_two || !input_full_irq_enable_two)
    else $error("input-full not cleared by slave read");
endmodule : hpc_channel_two_chk

bind hpc_channel_two hpc_channel_two_chk i_hpc_channel_two_chk (
  .core_clk, .rst_n, .standby, .host_port_enable, .input_full_irq_enable_two,
  .host_data_oe, .host_select_two_n, .alt_host_select_two_n, .host_fetch_strobe_n,
  .host_select_one_n, .host_write_ready, .slv_reg_sel, .slv_rd_n, .slv_wr_n,
  .slv_wdata, .slv_rdata, .irq_input_full_two, .select_pin_switch
);

// File: test/hpc_host_model.sv
/* Host processor model on the parallel bus of the second channel.
   Assumes the bench calls one task at a time, after a clock edge. */
module hpc_host_model (
  input  wire logic         core_clk,
  input  wire logic [7:0]   dev_data,
  input  wire logic         dev_oe,
  output hpc_pkg::hpc_pins_t pins
);
  timeunit 1ns;
  timeprecision 1ns;

  // Idle pins; the other channel is never selected
  initial begin
    pins = hpc_pkg::PINS_IDLE;
  end

  // Write; hold sets a prompt or slow low phase, data kept 4 cycles past rise
  task automatic put(input logic alt, input logic cmd, input logic [7:0] b,
                     input int unsigned hold);
    @(posedge core_clk) #2;
    pins.addr = cmd;
    pins.data = b;
    pins.sel_two_n = alt;
    pins.store_n = alt;
    pins.alt_sel_two_n = !alt;
    pins.alt_store_n = !alt;
    repeat (hold) @(posedge core_clk);
    #2 pins.store_n = 1'b1;
    pins.alt_store_n = 1'b1;
    repeat (4) @(posedge core_clk);
    #2 pins.sel_two_n = 1'b1;
    pins.alt_sel_two_n = 1'b1;
    pins.data = ~b;
  endtask : put

  // Read on primary pins; sampled only after the filter has settled
  task automatic get(input logic a, output logic [7:0] b, output logic oe);
    @(posedge core_clk) #2;
    pins.addr = a;
    pins.sel_two_n = 1'b0;
    pins.fetch_n = 1'b0;
    repeat (6) @(posedge core_clk);
    b = dev_data;
    oe = dev_oe;
    #2 pins.fetch_n = 1'b1;
    repeat (6) @(posedge core_clk);
    #2 pins.sel_two_n = 1'b1;
  endtask : get
endmodule : hpc_host_model

// File: test/tb_hpc_channel_two.sv
/* Bench for the second host port channel: slave driver and reference.
   Assumes the host model and the bound checker are compiled first. */
module tb_hpc_channel_two;
  timeunit 1ns;
  timeprecision 1ns;
  logic                  core_clk = 1'b0;
  logic                  rst_n = 1'b0;
  logic                  standby = 1'b0;
  logic                  host_port_enable = 1'b0;
  logic                  irq_en = 1'b0;
  hpc_pkg::hpc_reg_sel_t slv_reg_sel = hpc_pkg::HPC_SEL_STATUS;
  logic                  slv_rd_n = 1'b1;
  logic                  slv_wr_n = 1'b1;
  logic [7:0]            slv_wdata = 8'h00;
  logic [7:0]            slv_rdata, host_out, got;
  logic                  host_oe, wr_rdy, irq, pin_sw, oe;
  hpc_pkg::hpc_pins_t    pins;
  logic [31:0]           lfsr = 32'haf4991a0;
  int                    m_user, m_cmd, m_ibf, m_obf, m_in, m_out;
  int                    bad_count = 0;
  int                    total_checks = 0;
  int                    cyc = 0;

  always #10 core_clk = ~core_clk;

  hpc_channel_two i_hpc_channel_two (
    .core_clk(core_clk), .rst_n(rst_n), .standby(standby),
    .host_port_enable(host_port_enable), .input_full_irq_enable_two(irq_en),
    .host_data_in(pins.data), .host_data_out(host_out), .host_data_oe(host_oe),
    .host_addr_bit0(pins.addr), .host_select_two_n(pins.sel_two_n),
    .alt_host_select_two_n(pins.alt_sel_two_n), .host_store_strobe_n(pins.store_n),
    .alt_host_store_strobe_n(pins.alt_store_n), .host_fetch_strobe_n(pins.fetch_n),
    .host_select_one_n(pins.sel_one_n), .host_write_ready(wr_rdy),
    .slv_reg_sel(slv_reg_sel), .slv_rd_n(slv_rd_n), .slv_wr_n(slv_wr_n),
    .slv_wdata(slv_wdata), .slv_rdata(slv_rdata), .irq_input_full_two(irq),
    .select_pin_switch(pin_sw));

  hpc_host_model i_hpc_host_model (
    .core_clk(core_clk), .dev_data(host_out), .dev_oe(host_oe), .pins(pins));

  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nxt

  // Reference status built from the model flags
  function automatic logic [7:0] exp_st();
    return 8'(m_user + m_cmd * 8 + m_ibf * 2 + m_obf);
  endfunction : exp_st

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    total_checks++;
    if (g !== e) begin
      $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
      bad_count++;
    end
  endtask : chk

  // Slave strobes go high again between accesses to give a fresh edge
  task automatic slv_wr(input hpc_pkg::hpc_reg_sel_t s, input logic [7:0] d);
    @(posedge core_clk) #2;
    slv_reg_sel = s;
    slv_wdata = d;
    slv_wr_n = 1'b0;
    @(posedge core_clk) #2;
    slv_wr_n = 1'b1;
  endtask : slv_wr

  task automatic slv_rd(input hpc_pkg::hpc_reg_sel_t s, output logic [7:0] d);
    @(posedge core_clk) #2;
    slv_reg_sel = s;
    slv_rd_n = 1'b0;
    @(posedge core_clk) #2;
    slv_rd_n = 1'b1;
    d = slv_rdata;
  endtask : slv_rd

  task automatic rd_st();
    slv_rd(hpc_pkg::HPC_SEL_STATUS, got);
    chk(got, exp_st());
  endtask : rd_st

  // Host write, prompt or slow by the random bit; take says if it lands
  task automatic host_wr(input logic alt, input logic cmd, input logic [7:0] b, input bit take);
    i_hpc_host_model.put(alt, cmd, b, 2 + 3 * int'(lfsr[0]));
    repeat (6) @(posedge core_clk);
    if (take) begin
      m_in = b;
      m_cmd = cmd;
      m_ibf = 1;
    end
  endtask : host_wr

  task automatic give_verdict();
    if (bad_count == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : give_verdict

  // Hang guard; the sequence needs well under 3000 cycles
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      give_verdict();
    end
  end

  initial begin
    repeat (20) @(posedge core_clk);
    #2 rst_n = 1'b1;
    repeat (4) @(posedge core_clk);
    chk({6'h00, wr_rdy, irq}, 8'h02);
    rd_st();
    slv_rd(hpc_pkg::HPC_SEL_CONTROL, got);
    chk(got, 8'h00);
    host_port_enable = 1'b1;
    irq_en = 1'b1;
    // Data and command bytes alternate, each drained by the slave
    for (int i = 0; i < 4; i++) begin
      lfsr = nxt(lfsr);
      host_wr(1'b0, i[0], lfsr[7:0], 1'b1);
      chk({7'h00, irq}, 8'h01);
      rd_st();
      slv_rd(hpc_pkg::HPC_SEL_INPUT, got);
      chk(got, 8'(m_in));
      m_ibf = 0;
      rd_st();
    end
    // Only user bits accept slave writes; input byte refuses them
    slv_wr(hpc_pkg::HPC_SEL_STATUS, 8'hff);
    m_user = 8'hf4;
    rd_st();
    slv_wr(hpc_pkg::HPC_SEL_INPUT, ~lfsr[7:0]);
    slv_rd(hpc_pkg::HPC_SEL_INPUT, got);
    chk(got, 8'(m_in));
    // Output byte round trip, status read first must not clear full
    lfsr = nxt(lfsr);
    m_out = lfsr[7:0];
    slv_wr(hpc_pkg::HPC_SEL_OUTPUT, lfsr[7:0]);
    m_obf = 1;
    rd_st();
    slv_rd(hpc_pkg::HPC_SEL_OUTPUT, got);
    chk(got, 8'(m_out));
    i_hpc_host_model.get(1'b1, got, oe);
    chk(got, exp_st());
    chk({7'h00, oe}, 8'h01);
    i_hpc_host_model.get(1'b0, got, oe);
    chk(got, 8'(m_out));
    m_obf = 0;
    rd_st();
    // Pin switch: alternate pins land, primary pins are ignored
    slv_wr(hpc_pkg::HPC_SEL_CONTROL, 8'h08);
    chk({7'h00, pin_sw}, 8'h01);
    host_wr(1'b1, 1'b1, 8'h3c, 1'b1);
    rd_st();
    slv_rd(hpc_pkg::HPC_SEL_INPUT, got);
    chk(got, 8'h3c);
    m_ibf = 0;
    host_wr(1'b0, 1'b0, 8'hc3, 1'b0);
    rd_st();
    slv_wr(hpc_pkg::HPC_SEL_CONTROL, 8'h00);
    // Held slave read stalls the drain: two words fill, third dropped
    @(posedge core_clk) #2;
    slv_reg_sel = hpc_pkg::HPC_SEL_INPUT;
    slv_rd_n = 1'b0;
    host_wr(1'b0, 1'b0, 8'h11, 1'b0);
    host_wr(1'b0, 1'b1, 8'h22, 1'b1);
    chk({7'h00, wr_rdy}, 8'h00);
    host_wr(1'b0, 1'b0, 8'h33, 1'b0);
    @(posedge core_clk) #2;
    slv_rd_n = 1'b1;
    repeat (4) @(posedge core_clk);
    rd_st();
    slv_rd(hpc_pkg::HPC_SEL_INPUT, got);
    chk(got, 8'h22);
    m_ibf = 0;
    // Interrupt masked, then the whole port disabled
    irq_en = 1'b0;
    host_wr(1'b0, 1'b0, 8'h44, 1'b1);
    chk({7'h00, irq}, 8'h00);
    host_port_enable = 1'b0;
    host_wr(1'b0, 1'b1, 8'h55, 1'b0);
    rd_st();
    i_hpc_host_model.get(1'b0, got, oe);
    chk({7'h00, oe}, 8'h00);
    // Standby wipes status and control, including the output-full flag just set
    slv_wr(hpc_pkg::HPC_SEL_CONTROL, 8'hff);
    slv_wr(hpc_pkg::HPC_SEL_OUTPUT, 8'h5a);
    standby = 1'b1;
    @(posedge core_clk) #2;
    standby = 1'b0;
    m_user = 0;
    m_cmd = 0;
    m_ibf = 0;
    m_obf = 0;
    rd_st();
    slv_rd(hpc_pkg::HPC_SEL_CONTROL, got);
    chk(got, 8'h00);
    give_verdict();
  end
endmodule : tb_hpc_channel_two
